// >>> logic/attr_regs_defs.svh
// Offsets, field positions and reset values of the attribute register file.
// Assumes inclusion by bare name from the package; the design modules use its macros without including it.
`ifndef ATTR_REGS_DEFS_SVH
`define ATTR_REGS_DEFS_SVH

// ==========================================================
// Port address and index map
`define PORT_INDEX_DATA      10'h3c0
`define PORT_DATA_READ       10'h3c1
`define IDX_PALETTE_LAST     5'h0f
`define IDX_MODE_CONTROL     5'h10
`define IDX_BORDER_COLOUR    5'h11
`define IDX_PLANE_ENABLE     5'h12
`define IDX_PIXEL_PAN        5'h13
`define IDX_COLOUR_PAGE      5'h14

// ==========================================================
// Field positions and masks
`define INDEX_PAL_ENABLE_BIT 5
`define PALETTE_MASK         8'h3f
`define PLANE_ENABLE_MASK    8'h0f
`define PAN_MASK             8'h0f
`define COLOUR_PAGE_MASK     8'h0f
`define MODE_NINE_DOT_BIT    2
`define MODE_DUMMY_PEL_BIT   6
`define PAN_BIT3             3
`define LCD_TYPE_CODE        2'b01

// ==========================================================
// Reset values
`define RESET_BYTE           8'h00
`define RESET_INDEX          6'h00

`endif

// >>> logic/attr_regs_pkg.sv
// Types shared by the attribute register file modules.
// Assumes the constants header sits on the include path.
package attr_regs_pkg;
  `include "attr_regs_defs.svh"

  // Port access strobes from software
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } io_req_type;

  // Flip-flop toggle of index versus data at the shared port
  typedef enum logic [0:0] {
    ST_INDEX = 1'b0,
    ST_DATA  = 1'b1
  } port_phase_type;

  // Fields that steer the pixel path
  typedef struct packed {
    logic       nine_dot_eff;
    logic [3:0] pan_eff;
    logic       lcd_mode;
  } effect_type;
endpackage

// >>> logic/attr_effect.sv
// Derives effective display controls from stored mode bits.
// Assumes inputs come from registers on the same clock.
`timescale 1ns/1ns
module attr_effect
  import attr_regs_pkg::*;
(
  input  wire logic [1:0] display_type,
  input  wire logic [7:0] mode_control,
  input  wire logic [7:0] pan_reg,
  output      effect_type eff
);
  // ========================================================
  // LCD detection and gating of CRT-only bits
  always_comb
  begin
    eff.lcd_mode     = (display_type == `LCD_TYPE_CODE);
    eff.nine_dot_eff = mode_control[`MODE_NINE_DOT_BIT]
                       & ~eff.lcd_mode;
    eff.pan_eff      = eff.lcd_mode
                       ? {1'b0, pan_reg[2:0]}
                       : pan_reg[3:0];
  end
endmodule

// >>> logic/attr_reg_file.sv
// Attribute register file: index/data port, palette and control registers.
// Assumes one-cycle read and write strobes synchronous to clk_sys.
`timescale 1ns/1ns
module attr_reg_file
  import attr_regs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire io_req_type  io_req,
  input  wire logic        phase_reset,
  input  wire logic [1:0]  display_type_aux_register,
  output      logic [7:0]  rdata,
  output      logic        palette_enable,
  output      logic        nine_dot_enable,
  output      logic [3:0]  pan_count,
  output      logic        lcd_mode,
  output      logic [7:0]  mode_control_out,
  output      logic [7:0]  border_colour_out,
  output      logic [3:0]  plane_enable_out,
  output      logic [3:0]  colour_page_out
);
  // ========================================================
  // Storage
  logic [5:0]     palette_q [16];
  logic [7:0]     mode_control_q;
  logic [7:0]     border_colour_q;
  logic [7:0]     plane_enable_q;
  logic [7:0]     pixel_pan_q;
  logic [7:0]     colour_page_q;
  logic [5:0]     index_q;
  port_phase_type phase_q;
  effect_type     eff;

  // Index field without the palette enable bit
  function automatic logic [4:0] reg_index(input logic [5:0] idx);
    reg_index = idx[4:0];
  endfunction

  // Readback value of a register chosen by index
  function automatic logic [7:0] reg_value(input logic [4:0] i);
    reg_value = 8'h00;
    if (i <= `IDX_PALETTE_LAST)
      reg_value = {2'b00, palette_q[i[3:0]]};
    else
      unique case (i)
        `IDX_MODE_CONTROL:  reg_value = mode_control_q;
        `IDX_BORDER_COLOUR: reg_value = border_colour_q;
        `IDX_PLANE_ENABLE:  reg_value = plane_enable_q & `PLANE_ENABLE_MASK;
        `IDX_PIXEL_PAN:     reg_value = pixel_pan_q & `PAN_MASK;
        `IDX_COLOUR_PAGE:   reg_value = colour_page_q & `COLOUR_PAGE_MASK;
        default:            reg_value = 8'h00;
      endcase
  endfunction

  logic wr_port;
  logic rd_port;
  logic data_wr;
  assign wr_port = io_req.wr && (io_req.addr == `PORT_INDEX_DATA);
  assign rd_port = io_req.rd;
  assign data_wr = wr_port && (phase_q == ST_DATA);

  // ========================================================
  // Index/data toggle; status read elsewhere resets it
  always_ff @(posedge clk_sys)
  begin
    if (rst || phase_reset)
      phase_q <= ST_INDEX;
    else if (wr_port)
      phase_q <= (phase_q == ST_INDEX) ? ST_DATA : ST_INDEX;
  end

  // Index register write
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      index_q <= `RESET_INDEX;
    else if (wr_port && phase_q == ST_INDEX)
      index_q <= io_req.wdata[5:0];
  end

  // Palette entries
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int k = 0; k < 16; k++)
        palette_q[k] <= 6'h00;
    end
    else if (data_wr && reg_index(index_q) <= `IDX_PALETTE_LAST)
      palette_q[index_q[3:0]] <= io_req.wdata[5:0];
  end

  // Control registers; mode control bits 6 and 2 stored whole
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      mode_control_q  <= `RESET_BYTE;
      border_colour_q <= `RESET_BYTE;
      plane_enable_q  <= `RESET_BYTE;
      pixel_pan_q     <= `RESET_BYTE;
      colour_page_q   <= `RESET_BYTE;
    end
    else if (data_wr)
    begin
      unique case (reg_index(index_q))
        `IDX_MODE_CONTROL:  mode_control_q  <= io_req.wdata;
        `IDX_BORDER_COLOUR: border_colour_q <= io_req.wdata;
        `IDX_PLANE_ENABLE:  plane_enable_q  <= io_req.wdata & `PLANE_ENABLE_MASK;
        `IDX_PIXEL_PAN:     pixel_pan_q     <= io_req.wdata & `PAN_MASK;
        `IDX_COLOUR_PAGE:   colour_page_q   <= io_req.wdata & `COLOUR_PAGE_MASK;
        default:            mode_control_q  <= mode_control_q;
      endcase
    end
  end

  // Effective CRT-only controls
  attr_effect u_effect (
    .display_type (display_type_aux_register),
    .mode_control (mode_control_q),
    .pan_reg      (pixel_pan_q),
    .eff          (eff)
  );

  // ========================================================
  // Registered outputs; dummy pel bit masked from mode_control_out, still read back on rdata
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      rdata             <= 8'h00;
      palette_enable    <= 1'b0;
      nine_dot_enable   <= 1'b0;
      pan_count         <= 4'h0;
      lcd_mode          <= 1'b0;
      mode_control_out  <= 8'h00;
      border_colour_out <= 8'h00;
      plane_enable_out  <= 4'h0;
      colour_page_out   <= 4'h0;
    end
    else
    begin
      if (rd_port && io_req.addr == `PORT_INDEX_DATA)
        rdata <= {2'b00, index_q};
      else if (rd_port && io_req.addr == `PORT_DATA_READ)
        rdata <= reg_value(reg_index(index_q));
      palette_enable    <= index_q[`INDEX_PAL_ENABLE_BIT];
      nine_dot_enable   <= eff.nine_dot_eff;
      pan_count         <= eff.pan_eff;
      lcd_mode          <= eff.lcd_mode;
      mode_control_out  <= mode_control_q & ~(8'h01 << `MODE_DUMMY_PEL_BIT);
      border_colour_out <= border_colour_q;
      plane_enable_out  <= plane_enable_q[3:0];
      colour_page_out   <= colour_page_q[3:0];
    end
  end
endmodule

// >>> bench/attr_checker.sv
// Checker for the mode-gated outputs of the attribute register file.
// Assumes a bind to attr_reg_file from the bench top.
`timescale 1ns/1ns
module attr_checker
  import attr_regs_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic [1:0] display_type_aux_register,
  input wire logic       nine_dot_enable,
  input wire logic [3:0] pan_count,
  input wire logic       lcd_mode,
  input wire logic [7:0] mode_control_out
);
  // ==========================================
  // Display type gating and dummy pel masking
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic lcd_in = display_type_aux_register == 2'b01;

  lcd_detect_a: assert property (lcd_in [*3] |-> lcd_mode)
    else $error("lcd mode flag missing");
  crt_detect_a: assert property ((!lcd_in) [*3] |-> !lcd_mode)
    else $error("lcd mode flag in crt mode");
  nine_dot_lcd_a: assert property (lcd_in [*3] |-> !nine_dot_enable)
    else $error("nine dot active in lcd mode");
  nine_dot_crt_a: assert property ((!lcd_in) [*3] |->
    nine_dot_enable == mode_control_out[2])
    else $error("nine dot differs from mode bit");
  pan_bit3_lcd_a: assert property (lcd_in [*3] |-> !pan_count[3])
    else $error("pan bit 3 active in lcd mode");
  dummy_masked_a: assert property (mode_control_out[6] == 1'b0)
    else $error("dummy bit reached the display");
  // Main scenarios reached
  cover property (lcd_mode && pan_count == 4'h7);
  cover property (nine_dot_enable);
  cover property ($rose(lcd_mode));
endmodule

// >>> bench/tb_top.sv
// Directed bench for the attribute register file.
// Assumes package, design and checker compiled before this file.
`timescale 1ns/1ns
module tb_top
  import attr_regs_pkg::*;
;
  // ==========================================
  // Stimulus and design
  logic       clk_sys = 0, rst = 1, phase_reset = 0, nine_dot, lcd, pal_en;
  logic [1:0] dtype = 2'b00;
  logic [3:0] pan, plane, page;
  logic [7:0] rdata, mode_out, border;
  io_req_type io_req = '0;
  int         miscompares = 0, num_checks = 0;
  attr_reg_file DUT (.clk_sys(clk_sys), .rst(rst), .io_req(io_req),
    .phase_reset(phase_reset), .display_type_aux_register(dtype),
    .rdata(rdata), .palette_enable(pal_en), .nine_dot_enable(nine_dot),
    .pan_count(pan), .lcd_mode(lcd), .mode_control_out(mode_out),
    .border_colour_out(border), .plane_enable_out(plane),
    .colour_page_out(page));
  // Clock
  initial
    forever #20 clk_sys = ~clk_sys;
  task automatic check(logic [7:0] got, logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic op(logic w, logic r, logic [9:0] a, logic [7:0] d);
    @(posedge clk_sys) io_req <= '{w, r, a, d};
    @(posedge clk_sys) io_req <= '0;
  endtask
  // Index write with palette enable set, after a phase reset
  task automatic sel(logic [4:0] i);
    @(posedge clk_sys) phase_reset <= 1'b1;
    @(posedge clk_sys) phase_reset <= 1'b0;
    op(1'b1, 1'b0, 10'h3c0, {3'b001, i});
  endtask
  task automatic put(logic [4:0] i, logic [7:0] d);
    sel(i);
    op(1'b1, 1'b0, 10'h3c0, d);
  endtask
  task automatic chk_rd(logic [4:0] i, logic [7:0] exp);
    sel(i);
    op(1'b0, 1'b1, 10'h3c1, 8'h00);
    @(posedge clk_sys);
    #1 check(rdata, exp);
  endtask
  task automatic crt_check(logic [1:0] k);
    @(posedge clk_sys) dtype <= k;
    repeat (3) @(posedge clk_sys);
    #1 check({2'b00, lcd, nine_dot, pan}, 8'h1f);
  endtask
  task automatic t_dummy;
    put(5'h10, 8'h44);
    chk_rd(5'h10, 8'h44);
    check({mode_out[7:1], nine_dot}, 8'h05);
    put(5'h10, 8'h40);
    chk_rd(5'h10, 8'h40);
    check(mode_out, 8'h00);
    check({7'h0, nine_dot}, 8'h00);
    $display("dummy bit test done");
  endtask
  task automatic t_lcd;
    @(posedge clk_sys) dtype <= 2'b01;
    put(5'h10, 8'h04);
    put(5'h13, 8'h0f);
    chk_rd(5'h13, 8'h0f);
    check({2'b00, lcd, nine_dot, pan}, 8'h27);
    chk_rd(5'h10, 8'h04);
    for (int k = 0; k < 4; k++)
      if (k != 1)
        crt_check(2'(k));
    $display("lcd gating test done");
  endtask
  task automatic t_misc;
    put(5'h12, 8'hff);
    chk_rd(5'h12, 8'h0f);
    check({pal_en, 3'b000, plane}, 8'h8f);
    put(5'h0f, 8'hff);
    chk_rd(5'h0f, 8'h3f);
    put(5'h11, 8'ha5);
    chk_rd(5'h11, 8'ha5);
    check(border, 8'ha5);
    put(5'h14, 8'hff);
    chk_rd(5'h14, 8'h0f);
    check({4'h0, page}, 8'h0f);
    put(5'h15, 8'hff);
    chk_rd(5'h15, 8'h00);
    $display("plane and palette test done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    #1 check(mode_out, 8'h00);
    t_dummy;
    t_lcd;
    t_misc;
    final_report;
  end
  // Watchdog
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    miscompares++;
    final_report;
  end
endmodule
bind attr_reg_file attr_checker chk (.clk_sys(clk_sys), .rst(rst),
  .display_type_aux_register(display_type_aux_register),
  .nine_dot_enable(nine_dot_enable), .pan_count(pan_count),
  .lcd_mode(lcd_mode), .mode_control_out(mode_control_out));
